//--- include/token_host_pkg.sv
// Package with constants for the token space host controller
// Contract
// - Token space entered by select low; only address bits 0 to 2 choose flag.
// - Host holds RAM port select high while token select is low.
// - Flags active low; write zero to claim, write one to release.
// - Host drives select or output enable inactive between repeated reads.
// - Claim is write zero then read back; never read then write.
// - After failed claim host re-reads or writes one to withdraw.
// - At start host writes one to every flag to clear request latches.
package token_host_pkg;
    localparam int          DATA_W      = 9;
    localparam int          ADDR_W      = 16;
    localparam int          FLAG_W      = 3;
    localparam int          NUM_FLAGS   = 8;
    localparam int          CLK_NS      = 5;
    localparam int          SETUP_NS    = 20;
    localparam int          ACCESS_NS   = 20;
    localparam int          PULSE_NS    = 20;
    localparam int          GAP_NS      = 10;
    localparam int          SETUP_CYC   = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int          ACCESS_CYC  = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int          PULSE_CYC   = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int          GAP_CYC     = (GAP_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0]  CNT_ONE     = 4'h1;
    localparam logic [1:0]  OP_CLAIM    = 2'h0;
    localparam logic [1:0]  OP_RELEASE  = 2'h1;
    localparam logic [1:0]  OP_POLL     = 2'h2;
    localparam logic [1:0]  OP_INIT     = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_SETUP = 3'h1,
        ST_WRITE = 3'h3,
        ST_GAP   = 3'h2,
        ST_READ  = 3'h6,
        ST_DONE  = 3'h7
    } state_t;
endpackage

//--- design/token_host.sv
// Host controller driving the token space pins of one dual-port port
`timescale 1ns/1ps
module token_host
    import token_host_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Command port
    input  wire logic              cmd_valid,
    output wire logic              cmd_ready,
    input  wire logic [1:0]        cmd_op,
    input  wire logic [FLAG_W-1:0] cmd_flag,
    output logic                   rsp_valid,
    output logic                   rsp_owned,
    output logic                   rsp_failed,
    // Device pins
    output logic [ADDR_W-1:0]      addr,
    output logic                   ram_sel_n,
    output logic                   token_space_select_n,
    output logic                   rw_n,
    output logic                   oe_n,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe,
    input  wire logic [DATA_W-1:0] data_in
);
    state_t             state_q, state_d;
    logic [3:0]         cnt_q;
    logic [1:0]         op_q;
    logic [FLAG_W-1:0]  flag_q;
    logic               bit_q;
    logic               init_q;

    wire logic          cnt_done  = (cnt_q == CNT_ONE);
    wire logic          is_idle   = (state_q == ST_IDLE);
    wire logic          wr_one    = (cmd_op != OP_CLAIM);
    wire logic          skip_wr   = (op_q == OP_POLL);
    wire logic          need_rd   = (op_q == OP_CLAIM) || (op_q == OP_POLL);
    wire logic          last_init = (flag_q == FLAG_W'(NUM_FLAGS - 1));
    wire logic          rd_flag   = data_in[0];
    wire logic          take      = is_idle && cmd_valid;
    wire logic          init_step = (state_q == ST_GAP) && cnt_done && init_q && !last_init;
    wire logic [FLAG_W-1:0] flag_take = (cmd_op == OP_INIT) ? '0 : cmd_flag;
    wire logic [FLAG_W-1:0] flag_step = flag_q + FLAG_W'(1);
    wire logic [FLAG_W-1:0] flag_next = take ? flag_take : (init_step ? flag_step : flag_q);
    assign cmd_ready = is_idle;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:  if (cmd_valid) state_d = ST_SETUP;
            ST_SETUP: if (cnt_done) state_d = skip_wr ? ST_READ : ST_WRITE;
            ST_WRITE: if (cnt_done) state_d = ST_GAP;
            ST_GAP:   if (cnt_done) state_d = need_rd ? ST_READ : (init_q && !last_init ? ST_SETUP : ST_DONE);
            ST_READ:  if (cnt_done) state_d = ST_DONE;
            ST_DONE:  state_d = ST_IDLE;
            default:  state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            if (state_d != state_q || state_q == ST_DONE) begin
                case (state_d)
                    ST_SETUP: cnt_q <= 4'(SETUP_CYC);
                    ST_WRITE: cnt_q <= 4'(PULSE_CYC);
                    ST_GAP:   cnt_q <= 4'(GAP_CYC);
                    ST_READ:  cnt_q <= 4'(ACCESS_CYC);
                    default:  cnt_q <= 4'h0;
                endcase
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end

    // Command latch; init walks all flags
    always_ff @(posedge clk) begin
        if (rst) begin
            op_q   <= OP_CLAIM;
            bit_q  <= 1'b1;
            init_q <= 1'b0;
        end else if (take) begin
            op_q   <= cmd_op;
            bit_q  <= wr_one; // Zero claims, one releases
            init_q <= (cmd_op == OP_INIT);
        end
    end

    // Flag index, stepped while select is high
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_q <= '0;
        end else begin
            flag_q <= flag_next;
        end
    end

    wire logic sel_next  = (state_d == ST_SETUP) || (state_d == ST_WRITE) || (state_d == ST_READ);
    wire logic wr_next   = (state_d == ST_WRITE);
    wire logic rd_next   = (state_d == ST_READ);
    wire logic rd_done   = (state_q == ST_READ) && cnt_done;

    // RAM select held high, token select low only in access
    always_ff @(posedge clk) begin
        if (rst) begin
            ram_sel_n            <= 1'b1;
            token_space_select_n <= 1'b1;
            rw_n                 <= 1'b1;
            oe_n                 <= 1'b1;
        end else begin
            ram_sel_n            <= 1'b1;
            token_space_select_n <= !sel_next;
            rw_n                 <= !wr_next; // Write before read
            oe_n                 <= !rd_next; // Released between reads
        end
    end

    // Strobe sequencing checks
    ram_idle_a: assert property (@(posedge clk) disable iff (rst) ram_sel_n)
        else $error("ram select driven low");
    standby_a: assert property (@(posedge clk) disable iff (rst)
        is_idle |-> token_space_select_n && oe_n && rw_n && !data_oe)
        else $error("selected while idle");
    write_setup_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rw_n) |-> !$past(token_space_select_n))
        else $error("write strobe before select");
    write_sel_a: assert property (@(posedge clk) disable iff (rst)
        !rw_n |-> data_oe && oe_n && !token_space_select_n)
        else $error("write outside token space");
    write_len_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rw_n) |-> (!rw_n && data_oe) [*4])
        else $error("write pulse cut short");
    gap_len_a: assert property (@(posedge clk) disable iff (rst)
        $rose(rw_n) |-> token_space_select_n [*2])
        else $error("no select gap after write");
    read_sel_a: assert property (@(posedge clk) disable iff (rst) !oe_n |-> !token_space_select_n)
        else $error("read outside token space");
    read_bus_a: assert property (@(posedge clk) disable iff (rst)
        !oe_n |-> rw_n && !data_oe)
        else $error("bus driven during read");
    read_hold_a: assert property (@(posedge clk) disable iff (rst)
        $fell(oe_n) |-> (!oe_n && !token_space_select_n) [*4])
        else $error("read cut short");
    gap_reads_a: assert property (@(posedge clk) disable iff (rst)
        rd_done |-> $past(oe_n, ACCESS_CYC))
        else $error("read without select or oe release");
    select_end_a: assert property (@(posedge clk) disable iff (rst)
        $rose(oe_n) |-> token_space_select_n)
        else $error("select held after read");
    wr_before_rd_a: assert property (@(posedge clk) disable iff (rst)
        (!rw_n && op_q == OP_CLAIM) |-> ##[1:20] !oe_n)
        else $error("claim write not followed by read");
    poll_ro_a: assert property (@(posedge clk) disable iff (rst)
        (op_q == OP_POLL) |-> rw_n && !data_oe)
        else $error("poll drives a write");

    // Address follows the next flag index
    always_ff @(posedge clk) begin
        if (rst) begin
            addr <= '0;
        end else begin
            addr <= {{(ADDR_W-FLAG_W){1'b0}}, flag_next};
        end
    end

    // Address checks
    addr_upper_a: assert property (@(posedge clk) disable iff (rst) addr[ADDR_W-1:FLAG_W] == '0)
        else $error("upper address bits set");
    addr_stable_a: assert property (@(posedge clk) disable iff (rst)
        !token_space_select_n && !$past(token_space_select_n) |-> $stable(addr))
        else $error("address moved under select");

    // Write data on bit zero only
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= '0;
            data_oe  <= 1'b0;
        end else begin
            data_out <= {{(DATA_W-1){1'b0}}, bit_q};
            data_oe  <= wr_next;
        end
    end

    // Write data checks
    write_bit_a: assert property (@(posedge clk) disable iff (rst) data_oe |-> data_out[DATA_W-1:1] == '0)
        else $error("upper data bits set on write");
    claim_bit_a: assert property (@(posedge clk) disable iff (rst)
        (data_oe && op_q == OP_CLAIM) |-> data_out[0] == 1'b0)
        else $error("claim writes one");
    release_bit_a: assert property (@(posedge clk) disable iff (rst)
        (data_oe && op_q != OP_CLAIM) |-> data_out[0] == 1'b1)
        else $error("release writes zero");

    // Result: flag low on our side means owned
    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid  <= 1'b0;
            rsp_owned  <= 1'b0;
            rsp_failed <= 1'b0;
        end else begin
            rsp_valid <= (state_q == ST_DONE);
            if (rd_done) begin
                rsp_owned  <= !rd_flag;
                rsp_failed <= rd_flag;
            end else if (is_idle && cmd_valid) begin
                rsp_owned  <= 1'b0;
                rsp_failed <= 1'b0;
            end
        end
    end

    // Result checks
    owned_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |-> (need_rd ? (rsp_owned != rsp_failed) : !(rsp_owned || rsp_failed)))
        else $error("result bits inconsistent");
    rsp_pulse_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |=> !rsp_valid)
        else $error("result pulse too long");
    idle_ready_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid |-> cmd_ready)
        else $error("not ready after result");
    done_bound_a: assert property (@(posedge clk) disable iff (rst)
        (cmd_valid && cmd_ready) |-> ##[1:120] rsp_valid)
        else $error("command never completed");
endmodule

//--- test/token_dev.sv
// Behavioural token space model of the device, left pins and right write strobe
`timescale 1ns/1ps
module token_dev
    import token_host_pkg::*;
(
    // Left port pins
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              ram_sel_n,
    input  wire logic              token_space_select_n,
    input  wire logic              rw_n,
    input  wire logic              oe_n,
    input  wire logic [DATA_W-1:0] data_out,
    input  wire logic              data_oe,
    output logic [DATA_W-1:0]      data_in,
    // Right port
    input  wire logic              r_wr,
    input  wire logic [2:0]        r_flag,
    input  wire logic              r_val,
    output logic [NUM_FLAGS-1:0]   r_view
);
    logic [1:0] own_q [NUM_FLAGS] = '{default: 2'h3};
    logic       req_q [2][NUM_FLAGS];
    logic       wq, rq, q_q;
    wire        wact = !token_space_select_n && ram_sel_n && !rw_n && data_oe;
    wire        ract = !token_space_select_n && !oe_n;
    task automatic wr(input int s, input int f, input logic v);
        req_q[s - 1][f] = v;
        if (!v && own_q[f] == 2'h0) own_q[f] = 2'(s);
        else if (v && own_q[f] != 2'(3 - s)) own_q[f] = (req_q[2 - s][f] === 1'b0) ? 2'(3 - s) : 2'h0;
    endtask
    always @(posedge clk) begin
        wq <= wact;
        rq <= ract;
        if (wact && !wq) wr(1, int'(addr[2:0]), data_out[0]);
        if (r_wr) wr(2, int'(r_flag), r_val);
        if (ract && !rq) q_q <= (own_q[addr[2:0]] != 2'h1);
    end
    assign data_in = rq ? {DATA_W{q_q}} : {DATA_W{~q_q}};
    always_comb foreach (r_view[i]) r_view[i] = (own_q[i] != 2'h2);
endmodule

//--- test/tb_token_host.sv
// Self-checking bench for the token space host controller
`timescale 1ns/1ps
module tb_token_host;
    import token_host_pkg::*;
    logic clk = 0, rst = 1, cmd_valid = 0, r_wr = 0, r_val = 1;
    logic [1:0] cmd_op = 0;
    logic [2:0] cmd_flag = 0, r_flag = 0;
    wire logic cmd_ready, rsp_valid, rsp_owned, rsp_failed, ram_sel_n, token_space_select_n, rw_n, oe_n, data_oe;
    wire logic [ADDR_W-1:0] addr;
    wire logic [DATA_W-1:0] data_out, data_in;
    wire logic [NUM_FLAGS-1:0] r_view;
    int n_mismatch = 0, n_compared = 0, own[8], rl[8], rr[8], f, i;
    always #2.5 clk = ~clk;
    token_host u_token_host (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_flag(cmd_flag), .rsp_valid(rsp_valid), .rsp_owned(rsp_owned),
        .rsp_failed(rsp_failed), .addr(addr), .ram_sel_n(ram_sel_n), .token_space_select_n(token_space_select_n),
        .rw_n(rw_n), .oe_n(oe_n), .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
    token_dev u_token_dev (.clk(clk), .addr(addr), .ram_sel_n(ram_sel_n), .token_space_select_n(token_space_select_n),
        .rw_n(rw_n), .oe_n(oe_n), .data_out(data_out), .data_oe(data_oe), .data_in(data_in),
        .r_wr(r_wr), .r_flag(r_flag), .r_val(r_val), .r_view(r_view));
    task automatic summarize;
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    function automatic void apply(int s, int k, int v);
        if (s == 1) rl[k] = v;
        else rr[k] = v;
        if (v == 0 && own[k] == 0) own[k] = s;
        else if (v == 1 && own[k] != 3 - s) own[k] = ((s == 1 ? rr[k] : rl[k]) == 0) ? 3 - s : 0;
    endfunction
    task automatic cmd(input logic [1:0] op, input int k);
        int w;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_flag <= 3'(k);
        @(posedge clk);
        cmd_valid <= 1'b0;
        @(negedge clk);
        chk(cmd_ready, 1'b0);
        for (w = 0; w < 400 && rsp_valid !== 1'b1; w++) @(negedge clk);
        if (w == 400) begin
            n_mismatch++;
            summarize();
        end
        chk(cmd_ready, 1'b1);
        if (op == OP_INIT) for (w = 0; w < 8; w++) apply(1, w, 1);
        else if (op != OP_POLL) apply(1, k, op == OP_CLAIM ? 0 : 1);
        chk(rsp_owned, (op == OP_CLAIM || op == OP_POLL) && own[k] == 1);
        chk(rsp_failed, (op == OP_CLAIM || op == OP_POLL) && own[k] != 1);
    endtask
    task automatic rwr(input int k, input int v);
        @(posedge clk);
        r_wr <= 1'b1;
        r_flag <= 3'(k);
        r_val <= v[0];
        @(posedge clk);
        r_wr <= 1'b0;
        apply(2, k, v);
        @(negedge clk);
        chk(r_view[k], own[k] != 2);
    endtask
    initial begin
        for (i = 0; i < 8; i++) begin
            own[i] = 3;
            rl[i] = 2;
            rr[i] = 2;
        end
        void'($urandom(32'h574C9300));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i++) rwr(i, 1);
        cmd(OP_INIT, 0);
        $display("test init done");
        for (i = 0; i < 4; i++) begin
            f = $urandom % 8;
            cmd(OP_CLAIM, f);
            rwr(f, 0);
            cmd(OP_POLL, f);
            cmd(OP_RELEASE, f);
            cmd(OP_CLAIM, f);
            rwr(f, 1);
            cmd(OP_POLL, f);
            cmd(OP_RELEASE, f);
            rwr(f, 0);
            cmd(OP_POLL, f);
            rwr(f, 1);
            $display("test pass %0d done", i);
        end
        summarize();
    end
endmodule
